// [verilog/acr_pkg.sv]
// Package with register map, field layout and types of the ADC config register group
package acr_pkg;

    // Register offsets on the host register port
    localparam logic [7:0] ADDR_AVERAGING_CONTROL      = 8'h03;
    localparam logic [7:0] ADDR_OPERATING_MODE_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_CHANNEL_FUNCTION       = 8'h05;
    localparam logic [7:0] ADDR_DIGITAL_PIN_DIRECTION  = 8'h07;
    localparam logic [7:0] ADDR_OUTPUT_DRIVE_TYPE      = 8'h09;

    // Register and field widths
    localparam int unsigned REG_WIDTH     = 8;
    localparam int unsigned CHANNELS      = 8;
    localparam int unsigned AVG_WIDTH     = 3;
    localparam int unsigned DIV_WIDTH     = 4;
    localparam int unsigned SAMPLES_WIDTH = 8;

    // Field positions inside the averaging control register
    localparam int unsigned AVG_LSB = 0;
    localparam int unsigned AVG_MSB = 2;

    // Field positions inside the operating mode control register
    localparam int unsigned ERR_CONT_BIT = 7;
    localparam int unsigned MODE_MSB     = 6;
    localparam int unsigned MODE_LSB     = 5;
    localparam int unsigned OSCILLATOR_SELECT_BIT  = 4;
    localparam int unsigned DIV_MSB      = 3;
    localparam int unsigned DIV_LSB      = 0;

    // Reset values, all zero
    localparam logic [2:0] AVERAGING_RESET = 3'h0;
    localparam logic [7:0] OPMODE_RESET    = 8'h00;
    localparam logic [7:0] FUNCTION_RESET  = 8'h00;
    localparam logic [7:0] DIRECTION_RESET = 8'h00;
    localparam logic [7:0] DRIVE_RESET     = 8'h00;

    // Value read back from an unmapped address
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // Conversion start modes; upper two codes are reserved
    typedef enum logic [1:0] {
        ACR_MODE_MANUAL     = 2'b00,
        ACR_MODE_AUTONOMOUS = 2'b01,
        ACR_MODE_RSVD_2     = 2'b10,
        ACR_MODE_RSVD_3     = 2'b11
    } acr_conversion_start_mode_t;

    // Oscillator choices
    localparam logic OSC_HIGH_SPEED = 1'b0;
    localparam logic OSC_LOW_POWER  = 1'b1;

    // Operating mode control register layout
    typedef struct packed {
        logic                 error_continuation;
        acr_conversion_start_mode_t       conversion_start_mode;
        logic                 oscillator_select;
        logic [DIV_WIDTH-1:0] sample_rate_divider;
    } acr_opmode_t;

    // Per-channel pin configuration bundle
    typedef struct packed {
        logic [CHANNELS-1:0] function_gpio;
        logic [CHANNELS-1:0] direction_out;
        logic [CHANNELS-1:0] drive_push_pull;
    } acr_pin_cfg_t;

    // Pin drive bundle towards the pads
    typedef struct packed {
        logic [CHANNELS-1:0] out_level;
        logic [CHANNELS-1:0] oe_n;
        logic [CHANNELS-1:0] is_gpio;
    } acr_pin_drive_t;

endpackage

// [verilog/acr_pin_ctrl.sv]
// Per-channel pad control derived from the pin configuration
`timescale 1ns/1ns
module acr_pin_ctrl #(
    parameter int unsigned CHANNELS = 8
) (
    input  wire acr_pkg::acr_pin_cfg_t   i_cfg,
    input  wire logic [CHANNELS-1:0]     i_output_level_value,
    input  wire logic                    i_force_analog,
    output wire acr_pkg::acr_pin_drive_t o_drive
);

    // One slice per channel; purely combinational, registered by the parent
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch = ch + 1)
        begin : g_chan
            logic gpio_en;  // Channel acts as a digital pin
            logic out_en;   // Channel acts as a digital output
            logic drive_en; // Pad driver actually on

            // Forced analog wins over any stored configuration
            assign gpio_en = i_cfg.function_gpio[ch] & ~i_force_analog;
            // Direction only counts on a digital channel
            assign out_en = gpio_en & i_cfg.direction_out[ch];
            // Open-drain drives only a low; a high releases the pad
            assign drive_en = out_en & (i_cfg.drive_push_pull[ch]
                                        | ~i_output_level_value[ch]);
            // Push-pull output copies the level; analog, input or open-drain gives low
            assign o_drive.out_level[ch] = out_en & i_cfg.drive_push_pull[ch]
                                           & i_output_level_value[ch];
            // Enable is low while the pad is driven
            assign o_drive.oe_n[ch] = ~drive_en;
            assign o_drive.is_gpio[ch] = gpio_en;
        end
    endgenerate

endmodule

// [verilog/acr_config_regs.sv]
// Mode, averaging and pin configuration registers of the eight-channel ADC
//
// Summary of operation
// - Averaging code n averages two-to-n samples
// - Averaging register upper five bits read zero
// - Continuation off: CRC error changes nothing
// - Continuation on: force analog, pause until cleared
// - Mode 00 host starts, 01 internal starts
// - Oscillator bit: 0 high-speed, 1 low-power
// - Rate divider applies only in autonomous mode
// - Function bit: 0 analog, 1 digital pin
// - Direction bit: 0 input, 1 output
// - Drive bit: 0 open-drain, 1 push-pull
// - All registers reset to zero
// - Global force bit makes every channel analog
// - Digital outputs drive the output value bits
`timescale 1ns/1ns
module acr_config_regs #(
    parameter int unsigned CHANNELS = 8
) (
    input  wire logic                i_clock,
    input  wire logic                i_resetn,
    // Register port from the serial host front end
    input  wire logic                i_wr_en,
    input  wire logic                i_rd_en,
    input  wire logic [7:0]          i_addr,
    input  wire logic [7:0]          i_wr_data,
    output logic [7:0]               o_rd_data,
    output logic                     o_rd_valid,
    // Events and levels from neighbouring logic
    input  wire logic                i_crc_error,
    input  wire logic                i_input_crc_error_flag,
    input  wire logic                i_force_all_analog,
    input  wire logic [CHANNELS-1:0] i_output_level_value,
    input  wire logic                i_host_start,
    // Pads
    input  wire logic [CHANNELS-1:0] i_pin_in,
    output logic [CHANNELS-1:0]      o_pin_out,
    output logic [CHANNELS-1:0]      o_pin_oe_n,
    output logic [CHANNELS-1:0]      o_pin_level,
    output logic [CHANNELS-1:0]      o_channel_is_gpio,
    // Settings towards converter, sequencer and timing
    output logic [2:0]               o_averaging_ratio,
    output logic [7:0]               o_samples_per_result,
    output logic                     o_averaging_enable,
    output logic                     o_autonomous_mode,
    output logic                     o_conversion_start,
    output logic                     o_oscillator_select,
    output logic [3:0]               o_sample_rate_divider,
    output logic                     o_divider_active,
    output logic                     o_sequencing_paused
);

    // Whole state of the block in one record
    typedef struct packed {
        logic [acr_pkg::AVG_WIDTH-1:0]     averaging;     // Averaging code
        acr_pkg::acr_opmode_t              opmode;        // Mode control fields
        acr_pkg::acr_pin_cfg_t             pin_cfg;       // Channel config
        logic                              paused;        // CRC error hold
        logic [7:0]                        rd_data;       // Read answer
        logic                              rd_valid;      // Read answer strobe
        logic                              start;         // Conversion start
        logic [CHANNELS-1:0]               sync_a;        // Pad sync stage 1
        logic [CHANNELS-1:0]               sync_b;        // Pad sync stage 2
        logic [CHANNELS-1:0]               pin_out;       // Pad level
        logic [CHANNELS-1:0]               pin_oe_n;      // Pad enable, low drives
        logic [CHANNELS-1:0]               is_gpio;       // Effective function
        logic [acr_pkg::SAMPLES_WIDTH-1:0] samples;       // Samples per result
    } acr_state_t;

    acr_state_t             state_q;   // Registered state
    acr_state_t             state_d;   // Next state
    acr_pkg::acr_pin_drive_t pin_drive; // Combinational pad control
    logic                   force_analog; // Any reason to force analog
    logic                   autonomous;   // Decoded autonomous mode

    // Reset value of the whole record; every field starts at zero except pin_oe_n (all ones) and samples (8'h01)
    localparam acr_state_t STATE_RESET = '{
        averaging: acr_pkg::AVERAGING_RESET,
        opmode:    acr_pkg::OPMODE_RESET,
        pin_cfg:   '{function_gpio:   acr_pkg::FUNCTION_RESET,
                     direction_out:   acr_pkg::DIRECTION_RESET,
                     drive_push_pull: acr_pkg::DRIVE_RESET},
        paused:    1'b0,
        rd_data:   8'h00,
        rd_valid:  1'b0,
        start:     1'b0,
        sync_a:    '0,
        sync_b:    '0,
        pin_out:   '0,
        pin_oe_n:  '1,
        is_gpio:   '0,
        samples:   8'h01
    };

    // Samples that one result is built from; code zero means a single one
    function automatic logic [acr_pkg::SAMPLES_WIDTH-1:0] samples_for(
        input logic [acr_pkg::AVG_WIDTH-1:0] code
    );
        logic [acr_pkg::SAMPLES_WIDTH-1:0] one;
        one = 8'h01;
        samples_for = one << code;
    endfunction

    // Read answer for one address; unmapped and reserved bits give zero
    function automatic logic [7:0] read_mux(
        input logic [7:0] addr,
        input acr_state_t s
    );
        logic [7:0] data;
        data = acr_pkg::UNMAPPED_READ;
        case (addr)
            // Upper five bits have no storage at all
            acr_pkg::ADDR_AVERAGING_CONTROL:
                data = {5'h00, s.averaging};
            acr_pkg::ADDR_OPERATING_MODE_CONTROL:
                data = s.opmode;
            acr_pkg::ADDR_CHANNEL_FUNCTION:
                data = s.pin_cfg.function_gpio;
            acr_pkg::ADDR_DIGITAL_PIN_DIRECTION:
                data = s.pin_cfg.direction_out;
            acr_pkg::ADDR_OUTPUT_DRIVE_TYPE:
                data = s.pin_cfg.drive_push_pull;
            // Anything else reads as zero
            default:
                data = acr_pkg::UNMAPPED_READ;
        endcase
        read_mux = data;
    endfunction

    // Reserved mode codes fall back to manual behaviour
    always_comb
    begin
        case (state_q.opmode.conversion_start_mode)
            acr_pkg::ACR_MODE_AUTONOMOUS:
                autonomous = 1'b1;
            acr_pkg::ACR_MODE_MANUAL:
                autonomous = 1'b0;
            // Codes 10 and 11 act like manual
            default:
                autonomous = 1'b0;
        endcase
    end

    // Channels go analog on the global force bit or during a CRC hold
    assign force_analog = i_force_all_analog | state_q.paused;

    // Per-channel pad decoding
    acr_pin_ctrl #(
        .CHANNELS (CHANNELS)
    ) u_pin_ctrl (
        .i_cfg                (state_q.pin_cfg),
        .i_output_level_value (i_output_level_value),
        .i_force_analog       (force_analog),
        .o_drive              (pin_drive)
    );

    // Next-state logic for every field of the record
    always_comb
    begin
        state_d = state_q;

        // Register writes; each write lands one edge later
        if (i_wr_en)
        begin
            case (i_addr)
                // Only the low three bits are stored
                acr_pkg::ADDR_AVERAGING_CONTROL:
                    state_d.averaging = i_wr_data[acr_pkg::AVG_MSB:acr_pkg::AVG_LSB];
                acr_pkg::ADDR_OPERATING_MODE_CONTROL:
                    state_d.opmode = i_wr_data;
                acr_pkg::ADDR_CHANNEL_FUNCTION:
                    state_d.pin_cfg.function_gpio = i_wr_data;
                acr_pkg::ADDR_DIGITAL_PIN_DIRECTION:
                    state_d.pin_cfg.direction_out = i_wr_data;
                acr_pkg::ADDR_OUTPUT_DRIVE_TYPE:
                    state_d.pin_cfg.drive_push_pull = i_wr_data;
                // Writes elsewhere are dropped silently
                default:
                    state_d.rd_valid = state_d.rd_valid;
            endcase
        end

        // Registered read; the answer reflects the state before this edge
        state_d.rd_valid = i_rd_en;
        if (i_rd_en)
        begin
            state_d.rd_data = read_mux(i_addr, state_q);
        end
        else
        begin
            // Data holds when no read is under way
            state_d.rd_data = state_q.rd_data;
        end

        // CRC hold: released when the flag is cleared, but a new error wins
        if (!i_input_crc_error_flag)
        begin
            state_d.paused = 1'b0;
        end
        if (i_crc_error && state_q.opmode.error_continuation)
        begin
            state_d.paused = 1'b1;
        end
        // With continuation off an error leaves everything alone

        // Host starts count only in manual-like modes and outside a hold
        state_d.start = i_host_start & ~autonomous & ~state_q.paused;

        // Pad synchroniser; stage one feeds only stage two
        state_d.sync_a = i_pin_in;
        state_d.sync_b = state_q.sync_a;

        // Pad drive registered so pads never see decode glitches
        state_d.pin_out  = pin_drive.out_level;
        state_d.pin_oe_n = pin_drive.oe_n;
        state_d.is_gpio  = pin_drive.is_gpio;

        // Sample count follows the stored code
        state_d.samples = samples_for(state_d.averaging);
    end

    // State register; asynchronous reset loads constants only
    always_ff @(posedge i_clock or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            state_q <= STATE_RESET;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Register port answers
    assign o_rd_data  = state_q.rd_data;
    assign o_rd_valid = state_q.rd_valid;

    // Pads and effective channel function
    assign o_pin_out         = state_q.pin_out;
    assign o_pin_oe_n        = state_q.pin_oe_n;
    assign o_pin_level       = state_q.sync_b;
    assign o_channel_is_gpio = state_q.is_gpio;

    // Averaging settings; code zero switches averaging off
    assign o_averaging_ratio    = state_q.averaging;
    assign o_samples_per_result = state_q.samples;
    assign o_averaging_enable   = (state_q.averaging != acr_pkg::AVERAGING_RESET);

    // Conversion initiation
    assign o_autonomous_mode  = autonomous;
    assign o_conversion_start = state_q.start;

    // Timing source: low selects the high-speed oscillator
    assign o_oscillator_select = state_q.opmode.oscillator_select;

    // Divider is shown always but only valid in autonomous mode
    assign o_sample_rate_divider = state_q.opmode.sample_rate_divider;
    assign o_divider_active      = autonomous;

    // Sequencer must stall while the hold stands
    assign o_sequencing_paused = state_q.paused;

endmodule

// [verification/acr_config_regs_checker.sv]
// Port-level assertions for the ADC config register group
`timescale 1ns/1ns
module acr_config_regs_checker #(
    parameter int unsigned CHANNELS = 8
) (
    input  wire logic                i_clock,
    input  wire logic                i_resetn,
    input  wire logic                i_rd_en,
    input  wire logic [7:0]          i_addr,
    input  wire logic [7:0]          i_wr_data,
    input  wire logic                i_wr_en,
    input  wire logic [7:0]          o_rd_data,
    input  wire logic                o_rd_valid,
    input  wire logic                i_crc_error,
    input  wire logic                i_input_crc_error_flag,
    input  wire logic                i_force_all_analog,
    input  wire logic [CHANNELS-1:0] i_output_level_value,
    input  wire logic                i_host_start,
    input  wire logic [CHANNELS-1:0] o_pin_out,
    input  wire logic [CHANNELS-1:0] o_pin_oe_n,
    input  wire logic [CHANNELS-1:0] o_channel_is_gpio,
    input  wire logic [2:0]          o_averaging_ratio,
    input  wire logic [7:0]          o_samples_per_result,
    input  wire logic                o_autonomous_mode,
    input  wire logic                o_conversion_start,
    input  wire logic                o_sequencing_paused
);
    // One clock domain, so one default clock and reset for all
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_resetn);

    // Read answer follows the strobe by exactly one cycle
    rd_valid_a: assert property (o_rd_valid == $past(i_rd_en)) else $error("read valid timing");
    avg_reserved_a: assert property (i_rd_en && i_addr == 8'h03 |=> o_rd_data[7:3] == 5'h00)
        else $error("reserved averaging bits not zero");
    samples_a: assert property (o_samples_per_result == 8'h01 << o_averaging_ratio)
        else $error("sample count does not match averaging code");
    mode_wr_a: assert property (i_wr_en && i_addr == 8'h04 |=>
        o_autonomous_mode == ($past(i_wr_data[6:5]) == 2'b01)) else $error("mode decode wrong");
    start_a: assert property (i_host_start && !o_autonomous_mode && !o_sequencing_paused
        |=> o_conversion_start) else $error("host start lost");
    start_src_a: assert property (o_conversion_start |-> $past(i_host_start) &&
        !$past(o_autonomous_mode)) else $error("spurious conversion start");
    hold_keep_a: assert property (o_sequencing_paused && i_input_crc_error_flag
        |=> o_sequencing_paused) else $error("pause dropped while flag set");
    hold_clear_a: assert property (!i_input_crc_error_flag && !i_crc_error
        |=> !o_sequencing_paused) else $error("pause kept after flag cleared");
    paused_pads_a: assert property (o_sequencing_paused |=> o_pin_oe_n == '1 &&
        o_channel_is_gpio == '0) else $error("pads not analog while paused");
    force_pads_a: assert property (i_force_all_analog |=> o_pin_oe_n == '1 &&
        o_channel_is_gpio == '0 && o_pin_out == '0) else $error("force analog ignored");
    analog_off_a: assert property ((~o_channel_is_gpio & ~o_pin_oe_n) == '0)
        else $error("analog channel drives its pad");
    out_level_a: assert property (
        ((o_pin_out ^ $past(i_output_level_value)) & ~o_pin_oe_n) == '0)
        else $error("driven pad level differs from value");

    // Main scenarios reached
    pause_c: cover property ($rose(o_sequencing_paused));
    start_c: cover property (o_conversion_start);
    force_c: cover property (i_force_all_analog ##1 !i_force_all_analog);
endmodule
bind acr_config_regs acr_config_regs_checker #(.CHANNELS(CHANNELS)) u_chk (.*);

// [verification/acr_config_regs_tb_top.sv]
// Self-checking bench for the ADC config register group
`timescale 1ns/1ns
`define CHK(n,e,g) begin compares++; if ((g)!==(e)) begin errors++; $display("BAD %s %h %h",n,e,g); end end
module acr_config_regs_tb_top;
    logic       i_clock, i_resetn, i_wr_en, i_rd_en, i_crc_error, i_input_crc_error_flag;
    logic       i_force_all_analog, i_host_start, o_rd_valid, o_averaging_enable;
    logic       o_autonomous_mode, o_conversion_start, o_oscillator_select;
    logic       o_divider_active, o_sequencing_paused;
    logic [7:0] i_addr, i_wr_data, o_rd_data, i_output_level_value, i_pin_in, o_pin_out;
    logic [7:0] o_pin_oe_n, o_pin_level, o_channel_is_gpio, o_samples_per_result;
    logic [2:0] o_averaging_ratio;
    logic [3:0] o_sample_rate_divider;
    int         errors, compares;

    acr_config_regs #(.CHANNELS(8)) dut (.i_clock(i_clock), .i_resetn(i_resetn),
        .i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .i_addr(i_addr), .i_wr_data(i_wr_data),
        .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .i_crc_error(i_crc_error),
        .i_input_crc_error_flag(i_input_crc_error_flag), .i_force_all_analog(i_force_all_analog),
        .i_output_level_value(i_output_level_value), .i_host_start(i_host_start),
        .i_pin_in(i_pin_in), .o_pin_out(o_pin_out), .o_pin_oe_n(o_pin_oe_n),
        .o_pin_level(o_pin_level), .o_channel_is_gpio(o_channel_is_gpio),
        .o_averaging_ratio(o_averaging_ratio), .o_samples_per_result(o_samples_per_result),
        .o_averaging_enable(o_averaging_enable), .o_autonomous_mode(o_autonomous_mode),
        .o_conversion_start(o_conversion_start), .o_oscillator_select(o_oscillator_select),
        .o_sample_rate_divider(o_sample_rate_divider), .o_divider_active(o_divider_active),
        .o_sequencing_paused(o_sequencing_paused));

    // Verdict and end of run
    task automatic test_done;
        if (errors == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // One write strobe, released at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clock);
        i_wr_en   <= 1'b1;
        i_addr    <= a;
        i_wr_data <= d;
        @(posedge i_clock);
        i_wr_en <= 1'b0;
    endtask

    // One read strobe, bounded wait for the answer
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        int n;
        @(posedge i_clock);
        i_rd_en <= 1'b1;
        i_addr  <= a;
        @(posedge i_clock);
        i_rd_en <= 1'b0;
        n = 0;
        #1;
        while (o_rd_valid !== 1'b1)
        begin
            n++;
            if (n > 4)
            begin
                errors++;
                test_done();
            end
            @(posedge i_clock);
            #1;
        end
        `CHK("rd_data", e, o_rd_data)
    endtask

    // Pads lag a config change by two edges; three leaves margin
    task automatic settle;
        repeat (3) @(posedge i_clock);
        #1;
    endtask

    // Host start pulse and the expected conversion start
    task automatic hs(input logic e);
        @(posedge i_clock);
        i_host_start <= 1'b1;
        @(posedge i_clock);
        i_host_start <= 1'b0;
        #1;
        `CHK("conv_start", e, o_conversion_start)
    endtask

    // CRC error event pulse
    task automatic crc;
        @(posedge i_clock);
        i_crc_error <= 1'b1;
        @(posedge i_clock);
        i_crc_error <= 1'b0;
    endtask

    // Expected {is_gpio, oe_n, out}: function, direction, drive, value
    function automatic logic [23:0] pexp(input logic [7:0] f, d, p, v);
        logic [7:0] o;
        o = f & d;
        return {f, ~(o & (p | ~v)), o & p & v};
    endfunction

    task automatic chk_pads(input logic [23:0] e);
        settle();
        `CHK("pads", e, {o_channel_is_gpio, o_pin_oe_n, o_pin_out})
    endtask

    // Reset values, unmapped write and read
    task automatic t_reset;
        logic [7:0] am [5] = '{8'h03, 8'h04, 8'h05, 8'h07, 8'h09};
        `CHK("samples", 8'h01, o_samples_per_result)
        `CHK("pads", 24'h00ff00, {o_channel_is_gpio, o_pin_oe_n, o_pin_out})
        wr(8'h06, 8'hff);
        rd(8'h06, 8'h00);
        foreach (am[i]) rd(am[i], 8'h00);
    endtask

    // Every averaging code, reserved bits written high
    task automatic t_avg;
        for (int c = 0; c < 8; c++)
        begin
            wr(8'h03, {5'h1f, c[2:0]});
            rd(8'h03, {5'h00, c[2:0]});
            `CHK("samples", 8'h01 << c, o_samples_per_result)
            `CHK("avg_ratio", c[2:0], o_averaging_ratio)
            `CHK("avg_en", c != 0, o_averaging_enable)
        end
    endtask

    // Every conversion start mode, both oscillators, and four divider values
    task automatic t_mode;
        logic [7:0] d;
        for (int m = 0; m < 4; m++)
        begin
            d = {1'b0, m[1:0], m[0], 4'h9 ^ m[3:0]};
            wr(8'h04, d);
            rd(8'h04, d);
            `CHK("auto", m == 1, o_autonomous_mode)
            `CHK("div_act", m == 1, o_divider_active)
            `CHK("osc", m[0], o_oscillator_select)
            `CHK("div", d[3:0], o_sample_rate_divider)
            hs(m != 1);
        end
        wr(8'h04, 8'h00);
    endtask

    // Function, direction and drive per channel, then global force
    task automatic t_pins;
        wr(8'h05, 8'hf0);
        wr(8'h07, 8'hcc);
        wr(8'h09, 8'haa);
        rd(8'h09, 8'haa);
        for (int k = 0; k < 2; k++)
        begin
            @(posedge i_clock);
            i_output_level_value <= k ? 8'ha5 : 8'h5a;
            chk_pads(pexp(8'hf0, 8'hcc, 8'haa, k ? 8'ha5 : 8'h5a));
        end
        `CHK("pin_level", 8'h3c, o_pin_level)
        @(posedge i_clock);
        i_force_all_analog <= 1'b1;
        chk_pads(24'h00ff00);
        @(posedge i_clock);
        i_force_all_analog <= 1'b0;
        chk_pads(pexp(8'hf0, 8'hcc, 8'haa, 8'ha5));
    endtask

    // CRC error with continuation off, then on
    task automatic t_crc;
        @(posedge i_clock);
        i_input_crc_error_flag <= 1'b1;
        crc();
        chk_pads(pexp(8'hf0, 8'hcc, 8'haa, 8'ha5));
        `CHK("paused", 1'b0, o_sequencing_paused)
        wr(8'h04, 8'h80);
        crc();
        chk_pads(24'h00ff00);
        `CHK("paused", 1'b1, o_sequencing_paused)
        hs(1'b0);
        @(posedge i_clock);
        i_input_crc_error_flag <= 1'b0;
        chk_pads(pexp(8'hf0, 8'hcc, 8'haa, 8'ha5));
        `CHK("paused", 1'b0, o_sequencing_paused)
        hs(1'b1);
    endtask

    // Free-running clock
    initial
    begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // Hang guard
    initial
    begin
        repeat (20000) @(posedge i_clock);
        errors++;
        test_done();
    end

    // Main sequence
    initial
    begin
        {i_resetn, i_wr_en, i_rd_en, i_crc_error, i_input_crc_error_flag} = '0;
        {i_force_all_analog, i_host_start, i_addr, i_wr_data} = '0;
        i_output_level_value = 8'h00;
        i_pin_in = 8'h3c;
        errors = 0;
        compares = 0;
        repeat (5) @(posedge i_clock);
        i_resetn <= 1'b1;
        @(posedge i_clock);
        #1;
        t_reset();
        t_avg();
        t_mode();
        t_pins();
        t_crc();
        test_done();
    end
endmodule
